/* include/oaa_defs.svh */
// Constants of the operand addressing and arithmetic unit.
`ifndef OAA_DEFS_SVH
`define OAA_DEFS_SVH

// ----------------------------------------------------------------------------
// Start of the register space and core register addresses in the direct space
// ----------------------------------------------------------------------------
`define OAA_SFR_BASE   8'h80
`define OAA_SFR_ACC    8'he0
`define OAA_SFR_B      8'hf0
`define OAA_SFR_PSW    8'hd0
`define OAA_SFR_SP     8'h81
`define OAA_SFR_DPL    8'h82
`define OAA_SFR_DPH    8'h83

// ----------------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------------
`define OAA_PSW_CY     7
`define OAA_PSW_AC     6
`define OAA_PSW_RS1    4
`define OAA_PSW_RS0    3
`define OAA_PSW_OV     2
`define OAA_PSW_P      0

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define OAA_SP_RESET   8'h07
`define OAA_CYC_PER_MC 3
`define OAA_MC_ARITH   1
`define OAA_MC_MULDIV  2

`endif

/* include/oaa_pkg.sv */
// Types shared by the operand addressing and arithmetic unit.
package oaa_pkg;

  // Operations carried out by the unit.
  typedef enum logic [3:0] {
    OP_ADD      = 4'h0,
    OP_ADD_WITH_CARRY_OP     = 4'h1,
    OP_INC      = 4'h2,
    OP_INC_DATA_POINTER = 4'h3,
    OP_MUL      = 4'h4,
    OP_DIV      = 4'h5,
    OP_DA       = 4'h6,
    OP_MOVC     = 4'h7,
    OP_JMP      = 4'h8
  } oaa_op_e;

  // Ways of reaching the byte operand.
  typedef enum logic [3:0] {
    M_DIR        = 4'h0,
    M_IND_RI     = 4'h1,
    M_IND_RI_X   = 4'h2,
    M_IND_SP     = 4'h3,
    M_IND_DATA_POINTER_X = 4'h4,
    M_REG        = 4'h5,
    M_IMM        = 4'h6,
    M_ACC        = 4'h7,
    M_IDX_DATA_POINTER   = 4'h8,
    M_IDX_PC     = 4'h9
  } oaa_mode_e;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } oaa_fsm_e;

  // Whole state of the execution unit.
  typedef struct packed {
    oaa_fsm_e    fsm;
    logic [1:0]  ph;
    logic        mc;
    oaa_op_e     op;
    oaa_mode_e   mode;
    logic [2:0]  rsel;
    logic [7:0]  addr;
    logic [15:0] pc;
    logic [7:0]  ptr;
    logic [7:0]  opnd;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic [7:0]  program_status_word;
    logic [15:0] data_pointer;
    logic [7:0]  sp;
    logic        cmdReady;
    logic        done;
    logic        jmpValid;
    logic [15:0] jmpTarget;
    logic [7:0]  sfrAddr;
    logic        sfrRd;
    logic        sfrWr;
    logic [7:0]  sfrWdata;
    logic [15:0] codeAddr;
    logic        codeRd;
    logic [15:0] xAddr;
    logic        xRd;
  } oaa_state_s;

endpackage

/* verilog/oaa_data_ram.sv */
// Internal data RAM with a registered read port.
`timescale 1ns/1ps
module oaa_data_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock, reset and freeze.
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          clkEn,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  if (AW < 1 || DW < 1)
  begin : g_bad_size
    $error("oaa_data_ram: widths must be positive.");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array write; the array itself holds no reset.
  always_ff @(posedge ref_clk)
  begin
    if (clkEn && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read data leaves through a register, one cycle after the address.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rdata <= '0;
    end
    else if (clkEn)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

/* verilog/oaa_exec_unit.sv */
// Operand addressing and arithmetic execution unit of the core.
`timescale 1ns/1ps
`include "oaa_defs.svh"
module oaa_exec_unit #(
  parameter int CYC_PER_MC = `OAA_CYC_PER_MC
) (
  // Clock, reset and freeze.
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         clkEn,
  // Command port.
  input  wire logic         cmdValid,
  input  oaa_pkg::oaa_op_e   cmdOp,
  input  oaa_pkg::oaa_mode_e cmdMode,
  input  wire logic [2:0]   cmdReg,
  input  wire logic [7:0]   cmdAddr,
  input  wire logic [15:0]  cmdPc,
  output logic              cmdReady,
  output logic              cmdDone,
  // Store port into internal RAM and core registers.
  input  wire logic         stWr,
  input  wire logic [7:0]   stAddr,
  input  wire logic [7:0]   stData,
  // Special function register port.
  output logic [7:0]        sfrAddr,
  output logic              sfrRd,
  output logic              sfrWr,
  output logic [7:0]        sfrWdata,
  input  wire logic [7:0]   sfrRdata,
  // Program memory read port.
  output logic [15:0]       codeAddr,
  output logic              codeRd,
  input  wire logic [7:0]   codeData,
  // External data memory read port.
  output logic [15:0]       xAddr,
  output logic              xRd,
  input  wire logic [7:0]   xData,
  // Computed jump.
  output logic              jmpValid,
  output logic [15:0]       jmpTarget,
  // Core registers.
  output logic [7:0]        acc,
  output logic [7:0]        bReg,
  output logic [7:0]        programStatusWord,
  output logic [15:0]       dataPointer,
  output logic [7:0]        stackPointer
);
  import oaa_pkg::*;

  if (CYC_PER_MC != 3)
  begin : g_bad_mc
    $error("oaa_exec_unit: phase sequencing serves three clocks per cycle.");
  end

  localparam logic [1:0] PH_LAST = 2'(CYC_PER_MC - 1);

  oaa_state_s  st_q;
  oaa_state_s  st_d;
  logic        ramWe;
  logic [7:0]  ramWaddr;
  logic [7:0]  ramWdata;
  logic [7:0]  ramRaddr;
  logic [7:0]  ramRdata;
  logic [7:0]  opLive;
  logic [7:0]  incVal;
  logic [7:0]  wAddr;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [8:0]  daTmp;
  logic        daCy;
  logic [15:0] prod;
  logic        lastMc;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // RAM address of working register r in the bank chosen by the status word.
  function automatic logic [7:0] regAddr(input logic [7:0] program_status_word,
                                         input logic [2:0] r);
    regAddr = {3'h0, program_status_word[`OAA_PSW_RS1], program_status_word[`OAA_PSW_RS0], r};
  endfunction

  // True for direct addresses held inside this unit.
  function automatic logic localHit(input logic [7:0] a);
    localHit = (a == `OAA_SFR_ACC) || (a == `OAA_SFR_B) ||
               (a == `OAA_SFR_PSW) || (a == `OAA_SFR_SP) ||
               (a == `OAA_SFR_DPL) || (a == `OAA_SFR_DPH);
  endfunction

  // Reads a core register by its direct address.
  function automatic logic [7:0] localRead(input oaa_state_s s,
                                           input logic [7:0] a);
    case (a)
      `OAA_SFR_ACC: localRead = s.acc;
      `OAA_SFR_B:   localRead = s.b;
      `OAA_SFR_PSW: localRead = s.program_status_word;
      `OAA_SFR_SP:  localRead = s.sp;
      `OAA_SFR_DPL: localRead = s.data_pointer[7:0];
      `OAA_SFR_DPH: localRead = s.data_pointer[15:8];
      default:      localRead = 8'h00;
    endcase
  endfunction

  // Writes a core register by its direct address.
  function automatic oaa_state_s localWrite(input oaa_state_s s,
                                            input logic [7:0] a,
                                            input logic [7:0] v);
    localWrite = s;
    case (a)
      `OAA_SFR_ACC: localWrite.acc = v;
      `OAA_SFR_B:   localWrite.b = v;
      `OAA_SFR_PSW: localWrite.program_status_word = v;
      `OAA_SFR_SP:  localWrite.sp = v;
      `OAA_SFR_DPL: localWrite.data_pointer[7:0] = v;
      `OAA_SFR_DPH: localWrite.data_pointer[15:8] = v;
      default:      localWrite = s;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Internal data RAM
  // --------------------------------------------------------------------------

  oaa_data_ram #(
    .AW (8),
    .DW (8)
  ) u_ram (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .we      (ramWe),
    .waddr   (ramWaddr),
    .wdata   (ramWdata),
    .raddr   (ramRaddr),
    .rdata   (ramRdata)
  );

  // --------------------------------------------------------------------------
  // Datapath terms of the final phase
  // --------------------------------------------------------------------------

  // Operand as seen in the final phase; M_IND_RI and M_IND_RI_X reads arrive live.
  always_comb
  begin
    case (st_q.mode)
      M_IND_RI:   opLive = ramRdata;
      M_IND_RI_X: opLive = xData;
      default:    opLive = st_q.opnd;
    endcase
    incVal = opLive + 8'h01;
    lastMc = (st_q.op == OP_MUL || st_q.op == OP_DIV) ?
             1'(`OAA_MC_MULDIV - 1) : 1'(`OAA_MC_ARITH - 1);
  end

  // Target byte of an in-place increment.
  always_comb
  begin
    case (st_q.mode)
      M_IND_RI: wAddr = st_q.ptr;
      M_IND_SP: wAddr = st_q.sp;
      M_REG:    wAddr = regAddr(st_q.program_status_word, st_q.rsel);
      default:  wAddr = st_q.addr;
    endcase
  end

  // Adder, multiplier and decimal adjust.
  always_comb
  begin
    sum9 = {1'b0, st_q.acc} + {1'b0, opLive} +
           {8'h00, (st_q.op == OP_ADD_WITH_CARRY_OP) & st_q.program_status_word[`OAA_PSW_CY]};
    sum5 = {1'b0, st_q.acc[3:0]} + {1'b0, opLive[3:0]} +
           {4'h0, (st_q.op == OP_ADD_WITH_CARRY_OP) & st_q.program_status_word[`OAA_PSW_CY]};
    prod = st_q.acc * st_q.b;
    daTmp = {1'b0, st_q.acc};
    if (st_q.acc[3:0] > 4'h9 || st_q.program_status_word[`OAA_PSW_AC])
    begin
      daTmp = daTmp + 9'h006;
    end
    daCy = st_q.program_status_word[`OAA_PSW_CY] | daTmp[8];
    if (daTmp[7:4] > 4'h9 || daCy)
    begin
      daTmp = {1'b0, daTmp[7:0]} + 9'h060;
      daCy = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer and next state
  // --------------------------------------------------------------------------

  // Walks three phases per machine cycle and retires in the last one.
  always_comb
  begin
    st_d = st_q;
    ramWe = 1'b0;
    ramWaddr = 8'h00;
    ramWdata = 8'h00;
    ramRaddr = 8'h00;
    st_d.sfrRd = 1'b0;
    st_d.sfrWr = 1'b0;
    st_d.codeRd = 1'b0;
    st_d.xRd = 1'b0;
    st_d.done = 1'b0;
    st_d.jmpValid = 1'b0;
    case (st_q.fsm)
      ST_IDLE:
      begin
        if (stWr)
        begin
          if (stAddr < `OAA_SFR_BASE)
          begin
            ramWe = 1'b1;
            ramWaddr = stAddr;
            ramWdata = stData;
          end
          else
          begin
            st_d = localWrite(st_d, stAddr, stData);
          end
        end
        else if (cmdValid)
        begin
          st_d.op = cmdOp;
          st_d.mode = cmdMode;
          st_d.rsel = cmdReg;
          st_d.addr = cmdAddr;
          st_d.pc = cmdPc;
          st_d.ph = 2'h0;
          st_d.mc = 1'b0;
          st_d.cmdReady = 1'b0;
          st_d.fsm = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        st_d.ph = (st_q.ph == PH_LAST) ? 2'h0 : st_q.ph + 2'h1;
        if (st_q.ph == PH_LAST)
        begin
          st_d.mc = ~st_q.mc;
        end
        if (st_q.ph == 2'h0 && !st_q.mc)
        begin
          // First phase: choose the pointer or operand address.
          case (st_q.mode)
            M_DIR:
            begin
              ramRaddr = st_q.addr;
              st_d.sfrAddr = st_q.addr;
              st_d.sfrRd = (st_q.addr >= `OAA_SFR_BASE) &&
                           !localHit(st_q.addr);
            end
            M_REG:        ramRaddr = regAddr(st_q.program_status_word, st_q.rsel);
            M_IND_RI,
            M_IND_RI_X:   ramRaddr = regAddr(st_q.program_status_word,
                                             {2'h0, st_q.rsel[0]});
            M_IND_SP:     ramRaddr = st_q.sp;
            M_IND_DATA_POINTER_X:
            begin
              st_d.xAddr = st_q.data_pointer;
              st_d.xRd = 1'b1;
            end
            M_IMM:
            begin
              st_d.codeAddr = st_q.pc + 16'h0001;
              st_d.codeRd = 1'b1;
            end
            M_IDX_DATA_POINTER:
            begin
              st_d.codeAddr = st_q.data_pointer + {8'h00, st_q.acc};
              st_d.codeRd = 1'b1;
            end
            M_IDX_PC:
            begin
              st_d.codeAddr = st_q.pc + {8'h00, st_q.acc};
              st_d.codeRd = 1'b1;
            end
            default:      ramRaddr = 8'h00;
          endcase
        end
        else if (st_q.ph == 2'h1 && !st_q.mc)
        begin
          // Second phase: capture the operand or follow the pointer.
          st_d.ptr = ramRdata;
          ramRaddr = ramRdata;
          if (st_q.mode == M_IND_RI_X)
          begin
            st_d.xAddr = {8'h00, ramRdata};
            st_d.xRd = 1'b1;
          end
          case (st_q.mode)
            M_DIR:        st_d.opnd = (st_q.addr < `OAA_SFR_BASE) ? ramRdata :
                                      localHit(st_q.addr) ?
                                      localRead(st_q, st_q.addr) : sfrRdata;
            M_IMM,
            M_IDX_DATA_POINTER,
            M_IDX_PC:     st_d.opnd = codeData;
            M_IND_DATA_POINTER_X: st_d.opnd = xData;
            M_ACC:        st_d.opnd = st_q.acc;
            default:      st_d.opnd = ramRdata;
          endcase
        end
        else
        begin
          ramRaddr = st_q.ptr;
        end
        if (st_q.ph == PH_LAST && st_q.mc == lastMc)
        begin
          // Last phase of the last machine cycle: retire.
          st_d.fsm = ST_IDLE;
          st_d.cmdReady = 1'b1;
          st_d.done = 1'b1;
          case (st_q.op)
            OP_ADD,
            OP_ADD_WITH_CARRY_OP:
            begin
              st_d.acc = sum9[7:0];
              st_d.program_status_word[`OAA_PSW_CY] = sum9[8];
              st_d.program_status_word[`OAA_PSW_AC] = sum5[4];
              st_d.program_status_word[`OAA_PSW_OV] = (st_q.acc[7] == opLive[7]) &&
                                      (sum9[7] != st_q.acc[7]);
            end
            OP_INC:
            begin
              if (st_q.mode == M_ACC)
              begin
                st_d.acc = st_q.acc + 8'h01;
              end
              else if (st_q.mode == M_DIR && st_q.addr >= `OAA_SFR_BASE)
              begin
                if (localHit(st_q.addr))
                begin
                  st_d = localWrite(st_d, st_q.addr, incVal);
                end
                else
                begin
                  st_d.sfrAddr = st_q.addr;
                  st_d.sfrWdata = incVal;
                  st_d.sfrWr = 1'b1;
                end
              end
              else if (st_q.mode != M_IND_RI_X &&
                       st_q.mode != M_IND_DATA_POINTER_X)
              begin
                ramWe = 1'b1;
                ramWaddr = wAddr;
                ramWdata = incVal;
              end
            end
            OP_INC_DATA_POINTER:  st_d.data_pointer = st_q.data_pointer + 16'h0001;
            OP_MUL:
            begin
              st_d.b = prod[15:8];
              st_d.acc = prod[7:0];
              st_d.program_status_word[`OAA_PSW_CY] = 1'b0;
              st_d.program_status_word[`OAA_PSW_OV] = |prod[15:8];
            end
            OP_DIV:
            begin
              st_d.program_status_word[`OAA_PSW_CY] = 1'b0;
              st_d.program_status_word[`OAA_PSW_OV] = (st_q.b == 8'h00);
              if (st_q.b != 8'h00)
              begin
                st_d.acc = st_q.acc / st_q.b;
                st_d.b = st_q.acc % st_q.b;
              end
            end
            OP_DA:
            begin
              st_d.acc = daTmp[7:0];
              st_d.program_status_word[`OAA_PSW_CY] = daCy;
            end
            OP_MOVC:      st_d.acc = opLive;
            OP_JMP:
            begin
              st_d.jmpTarget = st_q.data_pointer + {8'h00, st_q.acc};
              st_d.jmpValid = 1'b1;
            end
            default:      st_d.done = 1'b1;
          endcase
        end
      end
      default:
      begin
        st_d.fsm = ST_IDLE;
        st_d.cmdReady = 1'b1;
      end
    endcase
    st_d.program_status_word[`OAA_PSW_P] = ^st_d.acc;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Whole state in one register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.fsm <= ST_IDLE;
      st_q.sp <= `OAA_SP_RESET;
      st_q.cmdReady <= 1'b1;
    end
    else if (clkEn)
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign cmdReady          = st_q.cmdReady;
  assign cmdDone           = st_q.done;
  assign sfrAddr           = st_q.sfrAddr;
  assign sfrRd             = st_q.sfrRd;
  assign sfrWr             = st_q.sfrWr;
  assign sfrWdata          = st_q.sfrWdata;
  assign codeAddr          = st_q.codeAddr;
  assign codeRd            = st_q.codeRd;
  assign xAddr             = st_q.xAddr;
  assign xRd               = st_q.xRd;
  assign jmpValid          = st_q.jmpValid;
  assign jmpTarget         = st_q.jmpTarget;
  assign acc               = st_q.acc;
  assign bReg              = st_q.b;
  assign programStatusWord = st_q.program_status_word;
  assign dataPointer       = st_q.data_pointer;
  assign stackPointer      = st_q.sp;

endmodule

/* test/oaa_exec_unit_assertions.sv */
// Port-level concurrent checks of the execution unit.
`timescale 1ns/1ps
module oaa_exec_unit_assertions
  import oaa_pkg::*;
#(
  parameter int CYC_PER_MC = 3
) (
  // Clock, reset and freeze.
  input wire logic         ref_clk,
  input wire logic         reset_n,
  input wire logic         clkEn,
  // Command port.
  input wire logic         cmdValid,
  input oaa_pkg::oaa_op_e   cmdOp,
  input oaa_pkg::oaa_mode_e cmdMode,
  input wire logic [15:0]  cmdPc,
  input wire logic         cmdReady,
  input wire logic         cmdDone,
  input wire logic         stWr,
  // Program memory and jump.
  input wire logic [15:0]  codeAddr,
  input wire logic         codeRd,
  input wire logic         jmpValid,
  input wire logic [15:0]  jmpTarget,
  // Core registers.
  input wire logic [7:0]   acc,
  input wire logic [7:0]   bReg,
  input wire logic [7:0]   programStatusWord,
  input wire logic [15:0]  dataPointer
);
  // A command is taken at an edge where the unit is idle and no store wins.
  logic take;
  logic long;
  assign take = cmdValid && cmdReady && !stWr && clkEn;
  assign long = cmdOp inside {OP_MUL, OP_DIV};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  arith_latency_a: assert property (take && !long |-> ##4 cmdDone)
    else $error("short operation did not retire after one machine cycle");
  muldiv_latency_a: assert property (take && long |=> !cmdDone [*6] ##1 cmdDone)
    else $error("multiply or divide did not retire after two cycles");
  machine_cycle_a: assert property (take && !long |=> !cmdReady [*3] ##1 cmdReady)
    else $error("busy window differs from three clocks");
  mul_product_a: assert property (take && cmdOp == OP_MUL |-> ##7
    {bReg, acc} == 16'($past(acc, 7)) * 16'($past(bReg, 7)))
    else $error("product not split across B and accumulator");
  div_result_a: assert property (take && cmdOp == OP_DIV && bReg != 8'h00
    |-> ##7 acc == $past(acc, 7) / $past(bReg, 7)
    && bReg == $past(acc, 7) % $past(bReg, 7))
    else $error("quotient or remainder wrong");
  data_pointer_step_a: assert property (take && cmdOp == OP_INC_DATA_POINTER |-> ##4
    dataPointer == $past(dataPointer, 4) + 16'h0001)
    else $error("data pointer did not step as one word");
  jump_target_a: assert property (take && cmdOp == OP_JMP |-> ##4 jmpValid
    && jmpTarget == $past(dataPointer, 4) + {8'h00, $past(acc, 4)})
    else $error("case jump target wrong");
  imm_fetch_a: assert property (take && cmdMode == M_IMM |-> ##2 codeRd
    && codeAddr == $past(cmdPc, 2) + 16'h0001)
    else $error("constant not fetched after the opcode");
  parity_track_a: assert property (programStatusWord[0] == ^acc)
    else $error("parity flag does not follow the accumulator");
endmodule

/* test/operand_addressing_arith_unit_tb.sv */
// Self-checking bench of the execution unit with a reference model.
`timescale 1ns/1ps
module operand_addressing_arith_unit_tb
  import oaa_pkg::*;
;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic ref_clk = 0, reset_n = 0, clkEn = 1, cmdValid = 0, stWr = 0;
  oaa_op_e cmdOp = OP_ADD;
  oaa_mode_e cmdMode = M_DIR;
  logic [2:0] cmdReg = 0;
  logic [7:0] cmdAddr = 0, stAddr = 0, stData = 0, sfrRdata, codeData, xData;
  logic [15:0] cmdPc = 0, codeAddr, xAddr, jmpTarget, dataPointer;
  logic cmdReady, cmdDone, sfrRd, sfrWr, codeRd, xRd, jmpValid;
  logic [7:0] sfrAddr, sfrWdata, acc, bReg, programStatusWord, stackPointer;
  int fails = 0, tests_run = 0, seed = 32'h9d77;
  logic [7:0] ma, mb, mp, ms, ram [256];
  logic [15:0] md;

  // Memory stand-ins show a scrambled value outside their read pulse.
  function automatic logic [7:0] hf(input logic [15:0] a, input logic [7:0] k);
    return a[7:0] ^ (a[15:8] + k * 8'h11) ^ 8'h5a;
  endfunction
  assign codeData = codeRd ? hf(codeAddr, 0) : ~hf(codeAddr, 0);
  assign xData = xRd ? hf(xAddr, 1) : ~hf(xAddr, 1);
  assign sfrRdata = sfrRd ? hf({8'h00, sfrAddr}, 2) : ~hf({8'h00, sfrAddr}, 2);

  always #20 ref_clk = ~ref_clk;

  oaa_exec_unit dut (.ref_clk, .reset_n, .clkEn, .cmdValid, .cmdOp, .cmdMode,
    .cmdReg, .cmdAddr, .cmdPc, .cmdReady, .cmdDone, .stWr, .stAddr, .stData,
    .sfrAddr, .sfrRd, .sfrWr, .sfrWdata, .sfrRdata, .codeAddr, .codeRd,
    .codeData, .xAddr, .xRd, .xData, .jmpValid, .jmpTarget, .acc, .bReg,
    .programStatusWord, .dataPointer, .stackPointer);

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One store while idle; the model follows it.
  task automatic st(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    {stWr, stAddr, stData} = {1'b1, a, d};
    @(posedge ref_clk) #1;
    stWr = 0;
    case (a)
      8'he0: ma = d;
      8'hf0: mb = d;
      8'hd0: mp = d;
      8'h81: ms = d;
      8'h82: md[7:0] = d;
      8'h83: md[15:8] = d;
      default: if (a < 8'h80) ram[a] = d;
    endcase
  endtask

  // Runs one command and compares latency, A, B, status word, data pointer, SFR write and jump with the model.
  task automatic exec(input oaa_op_e op, input oaa_mode_e m,
                      input logic [2:0] r, input logic [7:0] a,
                      input logic [15:0] pc);
    int loc, n;
    logic [15:0] t, jt;
    logic [7:0] v, bk, c;
    logic sw;
    bk = {3'b000, mp[4:3], 3'b000};
    loc = -1;
    v = 0;
    jt = 0;
    case (m)
      M_IMM: v = hf(pc + 16'h0001, 0);
      M_REG: loc = bk + r;
      M_DIR: if (a < 8'h80) loc = a; else v = hf({8'h00, a}, 2);
      M_IND_RI: loc = ram[bk + r[0]];
      M_IND_SP: loc = ms;
      M_IND_RI_X: v = hf({8'h00, ram[bk + r[0]]}, 1);
      M_IND_DATA_POINTER_X: v = hf(md, 1);
      M_ACC: v = ma;
      default: v = 0;
    endcase
    if (loc >= 0) v = ram[loc];
    sw = op == OP_INC && m == M_DIR && a >= 8'h80;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY_OP:
      begin
        c = (op == OP_ADD_WITH_CARRY_OP) ? {7'h00, mp[7]} : 8'h00;
        t = ma + v + c;
        mp[7] = t[8];
        mp[6] = (ma[3:0] + v[3:0] + c) > 15;
        mp[2] = ((ma ^ t[7:0]) & (v ^ t[7:0]) & 8'h80) != 0;
        ma = t[7:0];
      end
      OP_INC:
        if (m == M_ACC) ma++;
        else if (loc >= 0) ram[loc] = v + 8'h01;
      OP_INC_DATA_POINTER: md++;
      OP_MUL:
      begin
        t = ma * mb;
        {mp[7], mp[2]} = {1'b0, t > 255};
        {mb, ma} = t;
      end
      OP_DIV:
        if (mb == 0) {mp[7], mp[2]} = 2'b01;
        else {mp[7], mp[2], ma, mb} = {2'b00, ma / mb, ma % mb};
      OP_DA:
      begin
        t = ma;
        if (t[3:0] > 9 || mp[6]) t = t + 6;
        if (t > 16'h9f || mp[7]) {t, mp[7]} = {t + 16'h60, 1'b1};
        ma = t[7:0];
      end
      OP_MOVC: ma = hf(((m == M_IDX_PC) ? pc : md) + ma, 0);
      default: jt = md + ma;
    endcase
    @(posedge ref_clk) #1;
    {cmdValid, cmdOp, cmdMode, cmdReg, cmdAddr, cmdPc} = {1'b1, op, m, r, a, pc};
    @(posedge ref_clk) #1;
    cmdValid = 0;
    for (n = 0; n < 10 && cmdDone !== 1'b1; n++) @(posedge ref_clk) #1;
    if (n == 10)
    begin
      fails++;
      conclude();
    end
    chk(n, (op == OP_MUL || op == OP_DIV) ? 6 : 3);
    chk({acc, bReg}, {ma, mb});
    chk(programStatusWord, {mp[7:1], ^ma});
    chk(dataPointer, md);
    chk({sfrWr, sw ? sfrWdata : 8'h00}, {sw, sw ? v + 8'h01 : 8'h00});
    if (op == OP_JMP) chk({jmpValid, jmpTarget}, {1'b1, jt});
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    logic [31:0] rv;
    logic [7:0] ptr;
    oaa_mode_e m;
    oaa_op_e op;
    oaa_mode_e mt [8] = '{M_DIR, M_IND_RI, M_IND_RI_X, M_IND_SP,
                          M_IND_DATA_POINTER_X, M_REG, M_IMM, M_ACC};
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1;
    chk(stackPointer, 8'h07);
    chk({acc, programStatusWord, dataPointer}, 0);
    {ma, mb, mp, md, ms} = {32'h0, 8'h07};
    // Random operations over random banks, pointers and operands.
    repeat (80)
    begin
      rv = $random(seed);
      ptr = 8'h20 + rv[6:0] % 8'h60;
      st(8'he0, rv[31:24]);
      st(8'hf0, rv[9] ? 8'h00 : rv[23:16]);
      st(8'hd0, rv[15:8]);
      st(8'h82, rv[0] ? 8'hff : rv[7:0]);
      st(8'h83, rv[1] ? 8'hff : rv[15:8]);
      st({3'b000, mp[4:3], rv[12:10]}, rv[31:24] ^ 8'h3c);
      st({3'b000, mp[4:3], 2'b00, rv[10]}, ptr);
      st(ptr, rv[23:16] ^ 8'hc3);
      st(8'h81, ptr);
      op = oaa_op_e'($unsigned($random(seed)) % 9);
      m = mt[rv[18:16]];
      if (op == OP_MOVC) m = rv[20] ? M_IDX_PC : M_IDX_DATA_POINTER;
      if (op == OP_INC && m == M_IMM) m = M_REG;
      exec(op, m, rv[12:10], rv[21] ? 8'h90 : ptr, rv[31:16]);
      if (op == OP_INC || op == OP_ADD)
        exec(rv[22] ? OP_ADD : OP_DA, m, rv[12:10], rv[21] ? 8'h90 : ptr,
             rv[31:16]);
    end
    conclude();
  end
endmodule

bind oaa_exec_unit oaa_exec_unit_assertions #(.CYC_PER_MC(CYC_PER_MC)) chk_u (
  .ref_clk, .reset_n, .clkEn, .cmdValid, .cmdOp, .cmdMode, .cmdPc, .cmdReady,
  .cmdDone, .stWr, .codeAddr, .codeRd, .jmpValid, .jmpTarget, .acc, .bReg,
  .programStatusWord, .dataPointer);
